// ### shared/vco_band_params.svh
// Constants for the oscillator band search control block.
// Included by the package and by the band search control module; holds definitions only.
`ifndef VCO_BAND_PARAMS_SVH
`define VCO_BAND_PARAMS_SVH
`define BAND_W 7
`define BAND_LOW_END 7'h00
`define BAND_HIGH_END 7'h7f
`define BAND_START 7'h40
`define SEARCH_PD_CYCLES 1500
`define BAND_STEPS 7
`define CT_VOLT_RESET 5'h10
`define CT_VOLT_HIGH_BAND 5'h0c
`define LO_BUF_HIGH_FREQ 4'hc
`define BAND_FACTOR_RESET 2'h1
`define OSC_SEL_RESET 2'h0
`define LO_DIV_RESET 1'h0
`define CORE_I_RESET 3'h4
`define LO_BUF_RESET 4'h8
`endif

// ### shared/vco_band_pkg.sv
// Types shared by the band search control block.
// Assumes the constants header is on the include path.
`include "vco_band_params.svh"
package vco_band_pkg;
    // Search sequencer states.
    typedef enum logic [2:0] {
        st_idle,
        st_step,
        st_settle,
        st_done,
        st_lock
    } search_state_t;
    // Oscillator choice; code 3 is unused and falls back to the third.
    typedef logic [1:0] osc_sel_t;
endpackage : vco_band_pkg

// ### hdl/pd_tick_gen.sv
// Phase detector tick generator.
// Assumes the phase detector clock level arrives synchronous to the system clock.
`timescale 1ns/100ps
module pd_tick_gen (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_pd_clk,
    output logic o_tick
);
    // Previous level of the phase detector clock.
    logic prev_reg;

    // Store the level so a rising edge can be seen.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            prev_reg <= 1'b0;
        end else if (i_ce) begin
            prev_reg <= i_pd_clk;
        end
    end

    // One tick per rising phase detector edge.
    assign o_tick = i_ce & i_pd_clk & ~prev_reg;
endmodule : pd_tick_gen

// ### hdl/vco_band_select_control.sv
// Band search and oscillator setting control around a three oscillator core.
// Assumes all inputs are synchronous to i_clk_sys and the comparator is settled per tick.
//
// How it works
// - Select word picks one of three oscillators.
// - Band is a seven bit index, 128 bands.
// - Enable pin rising starts a band search.
// - Target comes from second bank frequency settings.
// - Capacitance switched in step by step.
// - Loop lock allowed only after search ends.
// - Chosen band shown in readable result field.
// - Result 0 or 127 means search failed.
// - Result 1 to 126 means success.
// - Search takes about 1500 detector clocks.
// - Search disabled uses preset band instead.
// - Coarse tune voltage resets to sixteen.
// - Divide oscillator output by two or four.
// - Core current word sets oscillator bias.
`timescale 1ns/100ps
`include "vco_band_params.svh"
module vco_band_select_control
    import vco_band_pkg::*;
#(
    parameter int SEARCH_CYCLES = `SEARCH_PD_CYCLES,
    parameter int BAND_WIDTH = `BAND_W
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_pd_clk,
    input wire logic i_chip_enable_pin,
    input wire logic i_band_search_enable,
    input wire logic [BAND_WIDTH-1:0] i_band_preset,
    input wire logic [1:0] i_oscillator_select,
    input wire logic i_lo_divide_select,
    input wire logic [2:0] i_oscillator_core_current,
    input wire logic [4:0] i_coarse_tune_voltage,
    input wire logic i_coarse_tune_voltage_wr,
    input wire logic [3:0] i_lo_buffer_current,
    input wire logic [1:0] i_band_select_factor,
    input wire logic i_osc_too_fast,
    output logic [BAND_WIDTH-1:0] o_band_result,
    output logic o_search_failed,
    output logic o_search_ok,
    output logic o_search_busy,
    output logic o_lock_allow,
    output logic [BAND_WIDTH-1:0] o_band_ctrl,
    output logic [2:0] o_osc_active,
    output logic o_lo_div4,
    output logic [2:0] o_core_bias,
    output logic [4:0] o_ct_voltage,
    output logic [3:0] o_lo_buffer_bias,
    output logic [1:0] o_band_factor
);
    // Width of the detector tick counter within one step.
    localparam int CW = 11;
    // Detector ticks per search step, whole search spread over seven steps.
    localparam logic [CW-1:0] STEP_TICKS = CW'(SEARCH_CYCLES / `BAND_STEPS);

    search_state_t state_reg;          // Sequencer state.
    logic en_prev_reg;                 // Enable pin level one cycle ago.
    logic [BAND_WIDTH-1:0] band_reg;   // Band applied to the resonator.
    logic [BAND_WIDTH-1:0] bit_reg;    // One hot trial bit of the search.
    logic [CW-1:0] tick_cnt_reg;       // Detector ticks within the step.
    logic [BAND_WIDTH-1:0] result_reg; // Readable band result.
    logic [4:0] ct_volt_reg;           // Coarse tuning voltage setting.
    logic pd_tick;                     // One cycle per detector edge.
    logic en_rise;                     // Enable pin rising.

    // Detector edge detector, driving the search pace.
    pd_tick_gen u_pd_tick_gen (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_pd_clk(i_pd_clk),
        .o_tick(pd_tick)
    );

    // Remember the enable level for edge detection.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            en_prev_reg <= 1'b0;
        end else if (i_ce) begin
            en_prev_reg <= i_chip_enable_pin;
        end
    end

    assign en_rise = i_ce & i_chip_enable_pin & ~en_prev_reg;

    // Successive approximation search: set a trial bit, keep it if too fast.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            state_reg <= st_idle;
            band_reg <= `BAND_START;
            bit_reg <= `BAND_START;
            tick_cnt_reg <= '0;
            result_reg <= '0;
        end else if (i_ce) begin
            if (en_rise && !i_band_search_enable) begin
                // Preset band applied directly, no search.
                band_reg <= i_band_preset;
                result_reg <= i_band_preset;
                state_reg <= st_lock;
            end else if (en_rise) begin
                // New search from mid band; target is on the comparator.
                band_reg <= `BAND_START;
                bit_reg <= `BAND_START;
                tick_cnt_reg <= '0;
                state_reg <= st_step;
            end else begin
                unique case (state_reg)
                    st_idle: begin
                        // Waiting for an enable rise.
                        tick_cnt_reg <= '0;
                    end
                    st_step: begin
                        // Let the oscillator settle for one step time.
                        if (pd_tick) begin
                            if (tick_cnt_reg == STEP_TICKS - CW'(1)) begin
                                tick_cnt_reg <= '0;
                                state_reg <= st_settle;
                            end else begin
                                tick_cnt_reg <= tick_cnt_reg + CW'(1);
                            end
                        end
                    end
                    st_settle: begin
                        // More capacitance lowers the frequency.
                        if (!i_osc_too_fast) begin
                            band_reg <= (band_reg & ~bit_reg) | (bit_reg >> 1);
                        end else begin
                            band_reg <= band_reg | (bit_reg >> 1);
                        end
                        bit_reg <= bit_reg >> 1;
                        state_reg <= (bit_reg == 7'h01) ? st_done : st_step;
                    end
                    st_done: begin
                        // Publish the chosen band.
                        result_reg <= band_reg;
                        state_reg <= st_lock;
                    end
                    st_lock: begin
                        // Loop may lock; stay until the enable pin falls.
                        if (!i_chip_enable_pin) begin
                            state_reg <= st_idle;
                        end
                    end
                endcase
            end
        end
    end

    // Final trial bit resolves the last band bit, reaching both ends 0 and 127.
    // Coarse tuning voltage starts at sixteen and follows host writes.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            ct_volt_reg <= `CT_VOLT_RESET;
        end else if (i_ce && i_coarse_tune_voltage_wr) begin
            ct_volt_reg <= i_coarse_tune_voltage;
        end
    end

    // Status decode of the result field.
    assign o_search_failed = (result_reg == `BAND_LOW_END) || (result_reg == `BAND_HIGH_END);
    assign o_search_ok = !o_search_failed;
    assign o_band_result = result_reg;
    assign o_search_busy = (state_reg == st_step) || (state_reg == st_settle);
    assign o_lock_allow = (state_reg == st_lock);
    assign o_band_ctrl = band_reg;
    assign o_ct_voltage = ct_volt_reg;

    logic [2:0] osc_active_reg; // One hot oscillator enable.
    logic lo_div4_reg;          // Divide by four when set.
    logic [2:0] core_bias_reg;  // Oscillator core bias word.
    logic [3:0] lo_buf_reg;     // LO buffer bias word.
    logic [1:0] factor_reg;     // Band select factor.

    // Settings pass through one flop stage so the core never sees a half changed word.
    // The core therefore follows a new setting one clock after it is driven.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            osc_active_reg <= 3'h1 << `OSC_SEL_RESET;
            lo_div4_reg <= `LO_DIV_RESET;
            core_bias_reg <= `CORE_I_RESET;
            lo_buf_reg <= `LO_BUF_RESET;
            factor_reg <= `BAND_FACTOR_RESET;
        end else if (i_ce) begin
            // One hot enable; select code 3 falls back to the third oscillator.
            osc_active_reg <= (i_oscillator_select == 2'h0) ? 3'h1 :
                              (i_oscillator_select == 2'h1) ? 3'h2 : 3'h4;
            lo_div4_reg <= i_lo_divide_select;
            core_bias_reg <= i_oscillator_core_current;
            // Buffer current and band factor are host choices.
            lo_buf_reg <= i_lo_buffer_current;
            factor_reg <= i_band_select_factor;
        end
    end

    // Registered settings drive the core.
    assign o_osc_active = osc_active_reg;
    assign o_lo_div4 = lo_div4_reg;
    assign o_core_bias = core_bias_reg;
    assign o_lo_buffer_bias = lo_buf_reg;
    assign o_band_factor = factor_reg;

    // Assertions.
    a_lock_after_search: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        o_lock_allow |-> !o_search_busy) else $error("lock during search");
    a_rise_starts: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        en_rise && i_band_search_enable |=> o_search_busy) else $error("no search");
    a_preset_loads: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        en_rise && !i_band_search_enable |=> o_band_result == $past(i_band_preset))
        else $error("preset not applied");
    a_fail_code: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        o_search_failed == (o_band_result == 7'h00 || o_band_result == 7'h7f))
        else $error("fail decode");
    a_ok_code: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        o_search_ok |-> o_band_result inside {[7'h01:7'h7e]}) else $error("ok decode");
    a_done_publish: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_ce && state_reg == st_done && !en_rise |=> o_band_result == $past(band_reg))
        else $error("result not published");
    a_ct_reset: assert property (@(posedge i_clk_sys)
        !i_rst && $past(i_rst) |-> o_ct_voltage == 5'h10) else $error("ct reset value");
    a_osc_onehot: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        $onehot(o_osc_active)) else $error("oscillator select");
    a_step_shift: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_ce && state_reg == st_settle && !en_rise |=> bit_reg == ($past(bit_reg) >> 1))
        else $error("step not advanced");
    c_search_done: cover property (@(posedge i_clk_sys) state_reg == st_done);
    c_preset_path: cover property (@(posedge i_clk_sys) en_rise && !i_band_search_enable);
    c_fail_result: cover property (@(posedge i_clk_sys) o_search_failed && o_lock_allow);
endmodule : vco_band_select_control

// ### tb/vco_core_model.sv
// Behavioural oscillator core and detector clock beside the band search block.
// Assumes the band word from the block settles within one system clock.
`timescale 1ns/100ps
module vco_core_model (
    input wire logic i_clk_sys,
    input wire logic [6:0] i_band_ctrl,
    input wire logic [6:0] i_target_band,
    output logic o_osc_too_fast,
    output logic o_pd_clk
);
    // Detector clock toggles each cycle, giving one tick every two cycles.
    initial o_pd_clk = 1'b0;
    initial o_osc_too_fast = 1'b0;
    always @(posedge i_clk_sys) begin
        o_pd_clk <= ~o_pd_clk;
    end
    // More capacitance lowers frequency, so the core runs fast up to the target band.
    always @(posedge i_clk_sys) begin
        o_osc_too_fast <= (i_band_ctrl <= i_target_band);
    end
endmodule : vco_core_model

// ### tb/vco_band_select_control_tb_top.sv
// Self-checking bench for the band search control block.
// Assumes a shortened search count of 14 detector ticks, two per trial step.
`timescale 1ns/100ps
module vco_band_select_control_tb_top;
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    logic ce = 1'b1;
    logic pin = 1'b0;
    logic search_en = 1'b1;
    logic [6:0] preset = 7'h00;
    logic [1:0] osc_sel = 2'h0;
    logic div = 1'b0;
    logic [2:0] core = 3'h4;
    logic [4:0] ct = 5'h10;
    logic ct_wr = 1'b0;
    logic [3:0] buf_i = 4'h8;
    logic [1:0] factor = 2'h1;
    logic [6:0] target = 7'h00;
    logic pd_clk, too_fast, o_search_failed, o_search_ok, o_search_busy, o_lock_allow, o_lo_div4;
    logic [6:0] o_band_result, o_band_ctrl;
    logic [2:0] o_osc_active, o_core_bias;
    logic [4:0] o_ct_voltage;
    logic [3:0] o_lo_buffer_bias;
    logic [1:0] o_band_factor;
    int miscompares = 0;
    int checked = 0;
    logic [6:0] tgts [6] = '{7'h00, 7'h01, 7'h40, 7'h7e, 7'h7f, 7'h25};
    // Clock at 200 MHz.
    always #2.5 i_clk_sys = ~i_clk_sys;
    vco_band_select_control #(.SEARCH_CYCLES(14)) u_vco_band_select_control (
        .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(ce), .i_pd_clk(pd_clk),
        .i_chip_enable_pin(pin), .i_band_search_enable(search_en), .i_band_preset(preset),
        .i_oscillator_select(osc_sel), .i_lo_divide_select(div),
        .i_oscillator_core_current(core), .i_coarse_tune_voltage(ct),
        .i_coarse_tune_voltage_wr(ct_wr), .i_lo_buffer_current(buf_i),
        .i_band_select_factor(factor), .i_osc_too_fast(too_fast),
        .o_band_result(o_band_result), .o_search_failed(o_search_failed),
        .o_search_ok(o_search_ok), .o_search_busy(o_search_busy), .o_lock_allow(o_lock_allow),
        .o_band_ctrl(o_band_ctrl), .o_osc_active(o_osc_active), .o_lo_div4(o_lo_div4),
        .o_core_bias(o_core_bias), .o_ct_voltage(o_ct_voltage),
        .o_lo_buffer_bias(o_lo_buffer_bias), .o_band_factor(o_band_factor));
    vco_core_model u_vco_core_model (.i_clk_sys(i_clk_sys), .i_band_ctrl(o_band_ctrl),
        .i_target_band(target), .o_osc_too_fast(too_fast), .o_pd_clk(pd_clk));
    // Compares one value and counts it.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask : chk
    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : tally_and_finish
    // Raises the pin, waits for lock under a bound, checks the outcome, drops the pin.
    task automatic run_search(input logic [6:0] tgt);
        int n;
        logic seen;
        n = 0;
        seen = 1'b0;
        @(posedge i_clk_sys);
        target <= tgt;
        pin <= 1'b1;
        @(negedge i_clk_sys);
        while (o_lock_allow !== 1'b1 && n < 200) begin
            if (o_search_busy === 1'b1) seen = 1'b1;
            n++;
            @(negedge i_clk_sys);
        end
        chk({7'h0, seen}, 8'h1, "busy seen");
        chk({7'h0, o_search_busy}, 8'h0, "busy at lock");
        chk((n >= 28 && n <= 60) ? 8'h1 : 8'h0, 8'h1, "duration");
        chk({1'b0, o_band_result}, {1'b0, tgt}, "result");
        chk({1'b0, o_band_ctrl}, {1'b0, tgt}, "band");
        chk({7'h0, o_search_failed}, (tgt == 0 || tgt == 127) ? 8'h1 : 8'h0, "fail");
        chk({7'h0, o_search_ok}, (tgt != 0 && tgt != 127) ? 8'h1 : 8'h0, "ok");
        @(posedge i_clk_sys);
        pin <= 1'b0;
        repeat (2) @(posedge i_clk_sys);
    endtask : run_search
    // Watchdog: far beyond the few hundred cycles the tests take.
    initial begin
        #20000;
        miscompares++;
        tally_and_finish();
    end
    // Main sequence.
    initial begin
        repeat (2) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        @(negedge i_clk_sys);
        chk({1'b0, o_band_result}, 8'h00, "rst result");
        chk({1'b0, o_band_ctrl}, 8'h40, "rst band");
        chk({3'h0, o_ct_voltage}, 8'h10, "rst ct");
        chk({6'h0, o_search_busy, o_lock_allow}, 8'h0, "rst idle");
        // Repeated searches stand in for temperature retriggers.
        foreach (tgts[i]) run_search(tgts[i]);
        // A second rise in mid-search restarts it.
        @(posedge i_clk_sys);
        pin <= 1'b1;
        repeat (10) @(posedge i_clk_sys);
        pin <= 1'b0;
        run_search(7'h5a);
        // Frozen clock enable ignores a rise.
        @(posedge i_clk_sys);
        ce <= 1'b0;
        pin <= 1'b1;
        repeat (4) @(negedge i_clk_sys);
        chk({6'h0, o_search_busy, o_lock_allow}, 8'h0, "ce frozen");
        @(posedge i_clk_sys);
        pin <= 1'b0;
        ce <= 1'b1;
        // Preset band skips the search.
        @(posedge i_clk_sys);
        search_en <= 1'b0;
        preset <= 7'h05;
        @(posedge i_clk_sys);
        pin <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        chk({6'h0, o_search_busy, o_lock_allow}, 8'h1, "preset lock");
        chk({1'b0, o_band_result}, 8'h05, "preset result");
        chk({1'b0, o_band_ctrl}, 8'h05, "preset band");
        // Oscillator select, divider and core current for each code.
        for (int s = 0; s < 4; s++) begin
            @(posedge i_clk_sys);
            osc_sel <= s[1:0];
            div <= s[0];
            core <= s[2:0] + 3'h3;
            // Settings reach the core one clock after they are driven.
            repeat (2) @(negedge i_clk_sys);
            chk({5'h0, o_osc_active}, 8'h1 << ((s > 2) ? 2 : s), "osc");
            chk({7'h0, o_lo_div4}, {7'h0, s[0]}, "div");
            chk({5'h0, o_core_bias}, {5'h0, s[2:0] + 3'h3}, "core");
        end
        @(posedge i_clk_sys);
        buf_i <= 4'hc;
        factor <= 2'h0;
        ct <= 5'h0c;
        ct_wr <= 1'b1;
        @(posedge i_clk_sys);
        ct_wr <= 1'b0;
        @(negedge i_clk_sys);
        chk({3'h0, o_ct_voltage}, 8'h0c, "ct write");
        chk({4'h0, o_lo_buffer_bias}, 8'h0c, "buffer");
        chk({6'h0, o_band_factor}, 8'h00, "factor");
        // A reset in mid-run returns the block to its idle values.
        @(posedge i_clk_sys);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        @(negedge i_clk_sys);
        chk({1'b0, o_band_result}, 8'h00, "rerst result");
        chk({1'b0, o_band_ctrl}, 8'h40, "rerst band");
        chk({3'h0, o_ct_voltage}, 8'h10, "rerst ct");
        chk({6'h0, o_search_busy, o_lock_allow}, 8'h0, "rerst idle");
        // The pin still stands high, so it counts as a rise and the preset loads.
        @(negedge i_clk_sys);
        chk({6'h0, o_search_busy, o_lock_allow}, 8'h1, "rise after reset");
        chk({1'b0, o_band_result}, 8'h05, "preset after reset");
        tally_and_finish();
    end
endmodule : vco_band_select_control_tb_top
